// *** hw/btod_core.sv ***
// Byte-transfer executor and operand decoder with a Wishbone register port.
// Assumes memory answers mem_rdy_i high at once for internal areas and
// holds it low for each external wait; all inputs synchronous to clk_i.
// Notes on behaviour
// - register index 0..7 picks one byte register, index 1 is the accumulator.
// - pair index 0..3 picks word accumulator then three pointer pairs.
// - short-direct byte operand maps its 8-bit field into FE20H..FF1FH.
// - short-direct word operand uses the same window, even addresses only.
// - special-register operands cannot reach FFD0H..FFDFH.
// - absolute operand spans whole space; word use needs even addresses.
// - 11-bit operand targets only 0800H..0FFFH.
// - 5-bit operand targets even addresses 0040H..007FH.
// - bit operand is a 3-bit index selecting one bit of a byte.
// - displacement is signed 8-bit, added to the program counter.
// - short count applies for internal high-speed RAM or no data access.
// - long count applies for every other data area.
// - each external read adds its read wait cycles.
// - each external write adds write waits; exchange adds both.
// - one count unit is one core clock cycle.
// - register load immediate takes 4 clocks.
// - accumulator load via pointer plus B takes 6, else 7 plus waits.
// - accumulator store via pointer plus B takes 6, else 7 plus waits.
// - accumulator load absolute takes 8, else 9 plus waits.
// - accumulator exchange absolute takes 8, else 10 plus both waits.
// - moves and exchanges keep flags unless the status word is written.
// - a restored flag comes back from the saved copy.
//
// The register offsets and the Wishbone interface to the registers were decided locally.
`timescale 1ns/10ps
module btod_core (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic mem_req_o,
  output logic mem_we_o,
  output logic [15:0] mem_addr_o,
  output logic [7:0] mem_wdata_o,
  input wire logic [7:0] mem_rdata_i,
  input wire logic mem_rdy_i,
  output logic busy_o,
  output logic done_o
);
  function automatic logic [31:0] lane_mask(input logic [3:0] sel);
    lane_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
  endfunction

  function automatic logic [15:0] saddr_map(input logic [7:0] off);
    if (off >= btod_pkg::SADDR_LO[7:0])
      saddr_map = {btod_pkg::SADDR_LO[15:8], off};
    else
      saddr_map = {btod_pkg::SADDR_HI[15:8], off};
  endfunction

  function automatic logic in_win(input logic [15:0] a, input logic [15:0] lo,
                                  input logic [15:0] hi);
    in_win = (a >= lo) && (a <= hi);
  endfunction

  // Returns {valid, address} for one operand kind and its field
  function automatic logic [16:0] dec_op(input logic [3:0] kind, input logic [15:0] f,
                                         input logic [15:0] pc);
    logic [15:0] a;
    logic ok;
    a = 16'h0000;
    ok = 1'b1;
    case (kind)
      btod_pkg::DK_SADDR: a = saddr_map(f[7:0]);
      btod_pkg::DK_SADDRP:
      begin
        a = saddr_map(f[7:0]);
        ok = ~f[0];
      end
      btod_pkg::DK_SFR, btod_pkg::DK_SFRP:
      begin
        a = {btod_pkg::SFR_BASE[15:8], f[7:0]};
        ok = ~in_win(a, btod_pkg::SFR_HOLE_LO, btod_pkg::SFR_HOLE_HI) &
             ~(kind == btod_pkg::DK_SFRP && f[0]);
      end
      btod_pkg::DK_ABS: a = f;
      btod_pkg::DK_ABSW:
      begin
        a = f;
        ok = ~f[0];
      end
      btod_pkg::DK_CTA: a = btod_pkg::CTA_LO | {5'h00, f[10:0]};
      btod_pkg::DK_VEC: a = btod_pkg::VEC_LO | {10'h000, f[4:0], 1'b0};
      btod_pkg::DK_BIT: a = 16'h0001 << f[2:0];
      btod_pkg::DK_DISP: a = pc + {{8{f[7]}}, f[7:0]};
      btod_pkg::DK_RP: a = {10'h000, f[1:0], 1'b1, f[1:0], 1'b0};
      btod_pkg::DK_R: a = {13'h0000, f[2:0]};
      default:
      begin
        a = 16'h0000;
        ok = 1'b0;
      end
    endcase
    dec_op = {ok, a};
  endfunction

  // Returns {legal, base count}; intl picks the short count when it exists
  function automatic logic [5:0] base_cnt(input logic [2:0] op, input logic [3:0] md,
                                          input logic intl);
    logic ld;
    logic xc;
    logic im;
    ld = (op == btod_pkg::OP_LOAD) || (op == btod_pkg::OP_STORE);
    xc = (op == btod_pkg::OP_XCHG);
    im = (op == btod_pkg::OP_IMM);
    base_cnt = 6'h00;
    case (md)
      btod_pkg::MD_REG:
        if (ld || xc)
          base_cnt = {1'b1, btod_pkg::CY_RR};
        else if (im)
          base_cnt = {1'b1, btod_pkg::CY_RI};
      btod_pkg::MD_SADDR:
        if (ld)
          base_cnt = {1'b1, intl ? btod_pkg::CY_SAD_S : btod_pkg::CY_SAD_L};
        else if (im)
          base_cnt = {1'b1, intl ? btod_pkg::CY_SADI_S : btod_pkg::CY_SADI_L};
        else if (xc)
          base_cnt = {1'b1, intl ? btod_pkg::CY_SAD_S : btod_pkg::CY_SADX_L};
      btod_pkg::MD_SFR:
        if (ld)
          base_cnt = {1'b1, btod_pkg::CY_SAD_L};
        else if (im)
          base_cnt = {1'b1, btod_pkg::CY_SADI_L};
        else if (xc)
          base_cnt = {1'b1, btod_pkg::CY_SADX_L};
      btod_pkg::MD_ABS:
        if (ld)
          base_cnt = {1'b1, intl ? btod_pkg::CY_ABS_S : btod_pkg::CY_ABS_L};
        else if (xc)
          base_cnt = {1'b1, intl ? btod_pkg::CY_ABS_S : btod_pkg::CY_ABSX_L};
      btod_pkg::MD_DE, btod_pkg::MD_HL:
        if (ld)
          base_cnt = {1'b1, intl ? btod_pkg::CY_SAD_S : btod_pkg::CY_SAD_L};
        else if (xc)
          base_cnt = {1'b1, intl ? btod_pkg::CY_SAD_S : btod_pkg::CY_SADX_L};
      btod_pkg::MD_HLBYTE:
        if (ld)
          base_cnt = {1'b1, intl ? btod_pkg::CY_ABS_S : btod_pkg::CY_ABS_L};
        else if (xc)
          base_cnt = {1'b1, intl ? btod_pkg::CY_ABS_S : btod_pkg::CY_ABSX_L};
      btod_pkg::MD_HLB, btod_pkg::MD_HLC:
        if (ld)
          base_cnt = {1'b1, intl ? btod_pkg::CY_HLBC_S : btod_pkg::CY_HLBC_L};
        else if (xc)
          base_cnt = {1'b1, intl ? btod_pkg::CY_ABS_S : btod_pkg::CY_ABSX_L};
      btod_pkg::MD_PSW:
        if (ld)
          base_cnt = {1'b1, btod_pkg::CY_SAD_L};
        else if (im)
          base_cnt = {1'b1, btod_pkg::CY_SADI_L};
      default: base_cnt = 6'h00;
    endcase
    if (op == btod_pkg::OP_PSAVE || op == btod_pkg::OP_PREST)
      base_cnt = {1'b1, btod_pkg::CY_PSWOP};
  endfunction

  btod_pkg::btod_state_t state_q, state_d;
  logic ack_q;
  logic [31:0] rdat_q;
  logic [31:0] cmd_q;
  logic [15:0] addr_q, pc_q, dec_fld_q, ea_q;
  logic [3:0] dec_kind_q;
  logic [7:0] gpr_q [8];
  logic [7:0] psw_q, psw_sv_q, tmp_q;
  logic [4:0] cnt_q, base_q;
  logic [7:0] tot_q, wait_q, last_cyc_q;
  logic done_q, err_q, intl_q, req_q, we_q;
  logic [15:0] maddr_q;
  logic [7:0] mwdata_q;

  wire bus_req = wb_cyc_i & wb_stb_i & ~ack_q;
  wire wr_en = bus_req & wb_we_i;
  wire idle = (state_q == btod_pkg::BTOD_S_IDLE);
  wire [31:0] wmask = lane_mask(wb_sel_i);
  wire hit_cmd = (wb_adr_i == btod_pkg::OFS_CMD);
  wire hit_addr = (wb_adr_i == btod_pkg::OFS_ADDR);
  wire hit_stat = (wb_adr_i == btod_pkg::OFS_STAT);
  wire hit_psw = (wb_adr_i == btod_pkg::OFS_PSW);
  wire hit_dec = (wb_adr_i == btod_pkg::OFS_DEC);
  wire hit_pc = (wb_adr_i == btod_pkg::OFS_PC);
  wire hit_gpr = (wb_adr_i[7:5] == btod_pkg::OFS_GPR[7:5]) && (wb_adr_i[1:0] == 2'h0);
  wire [2:0] gpr_sel = wb_adr_i[4:2];
  wire go = wr_en & hit_cmd & idle & wb_sel_i[3] & wb_dat_i[btod_pkg::CMD_GO_BIT];
  wire [2:0] op_w = cmd_q[btod_pkg::CMD_OP_LSB +: 3];
  wire [3:0] md_w = cmd_q[btod_pkg::CMD_MODE_LSB +: 4];
  wire [2:0] ri_w = cmd_q[btod_pkg::CMD_REG_LSB +: 3];
  wire [7:0] imm_w = cmd_q[btod_pkg::CMD_IMM_LSB +: 8];
  wire [7:0] acc_w = gpr_q[btod_pkg::IDX_A];
  wire [15:0] hl_w = {gpr_q[btod_pkg::IDX_H], gpr_q[btod_pkg::IDX_L]};
  wire [15:0] de_w = {gpr_q[btod_pkg::IDX_D], gpr_q[btod_pkg::IDX_E]};
  wire [16:0] dec_w = dec_op(dec_kind_q, dec_fld_q, pc_q);
  wire [15:0] dec_res_w = dec_w[15:0];
  wire dec_ok_w = dec_w[16];
  wire mem_md_w = (md_w >= btod_pkg::MD_SADDR) && (md_w <= btod_pkg::MD_HLC) &&
                  (op_w <= btod_pkg::OP_IMM);
  wire [15:0] ea_w = (md_w == btod_pkg::MD_SADDR) ? saddr_map(addr_q[7:0]) :
                     (md_w == btod_pkg::MD_SFR) ? {btod_pkg::SFR_BASE[15:8], addr_q[7:0]} :
                     (md_w == btod_pkg::MD_ABS) ? addr_q :
                     (md_w == btod_pkg::MD_DE) ? de_w :
                     (md_w == btod_pkg::MD_HL) ? hl_w :
                     (md_w == btod_pkg::MD_HLBYTE) ? hl_w + {8'h00, addr_q[7:0]} :
                     (md_w == btod_pkg::MD_HLB) ? hl_w + {8'h00, gpr_q[btod_pkg::IDX_B]} :
                     (md_w == btod_pkg::MD_HLC) ? hl_w + {8'h00, gpr_q[btod_pkg::IDX_C]} :
                     16'h0000;
  wire sfr_hole_w = (md_w == btod_pkg::MD_SFR) &&
                    in_win(ea_w, btod_pkg::SFR_HOLE_LO, btod_pkg::SFR_HOLE_HI);
  wire intl_w = ~mem_md_w || in_win(ea_w, btod_pkg::HRAM_LO, btod_pkg::HRAM_HI);
  wire [5:0] base_w = base_cnt(op_w, md_w, intl_w);
  wire legal_w = base_w[5] & ~sfr_hole_w;
  wire stall_w = req_q & ~mem_rdy_i;
  wire rd_ack = (state_q == btod_pkg::BTOD_S_RD) & mem_rdy_i;
  wire wr_ack = (state_q == btod_pkg::BTOD_S_WR) & mem_rdy_i;
  wire fin_w = (state_q == btod_pkg::BTOD_S_PAD) && (cnt_q == base_q - 5'h01);
  wire psw_op_w = (md_w == btod_pkg::MD_PSW) && (op_w != btod_pkg::OP_LOAD);
  wire [31:0] stat_w = {ea_q, last_cyc_q, 4'h0, intl_q, err_q, done_q, ~idle};
  wire [31:0] rmux_w = hit_cmd ? cmd_q :
                       hit_addr ? {16'h0000, addr_q} :
                       hit_stat ? stat_w :
                       hit_psw ? {16'h0000, psw_sv_q, psw_q} :
                       hit_dec ? {15'h0000, dec_ok_w, dec_res_w} :
                       hit_pc ? {16'h0000, pc_q} :
                       hit_gpr ? {24'h000000, gpr_q[gpr_sel]} : 32'h00000000;

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      btod_pkg::BTOD_S_IDLE:
        if (go)
          state_d = btod_pkg::BTOD_S_DISP;
      btod_pkg::BTOD_S_DISP:
        if (!legal_w)
          state_d = btod_pkg::BTOD_S_IDLE;
        else if (!mem_md_w)
          state_d = btod_pkg::BTOD_S_PAD;
        else if (op_w == btod_pkg::OP_LOAD || op_w == btod_pkg::OP_XCHG)
          state_d = btod_pkg::BTOD_S_RD;
        else
          state_d = btod_pkg::BTOD_S_WR;
      btod_pkg::BTOD_S_RD:
        if (mem_rdy_i)
          state_d = (op_w == btod_pkg::OP_XCHG) ? btod_pkg::BTOD_S_WR :
                    btod_pkg::BTOD_S_PAD;
      btod_pkg::BTOD_S_WR:
        if (mem_rdy_i)
          state_d = btod_pkg::BTOD_S_PAD;
      btod_pkg::BTOD_S_PAD:
        if (fin_w)
          state_d = btod_pkg::BTOD_S_IDLE;
      default: state_d = btod_pkg::BTOD_S_IDLE;
    endcase
  end

  // Bus side: one wait state, unmapped reads give zero, writes there are dropped
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_q <= 1'b0;
      rdat_q <= 32'h00000000;
      cmd_q <= 32'h00000000;
      addr_q <= 16'h0000;
      pc_q <= 16'h0000;
      dec_kind_q <= 4'h0;
      dec_fld_q <= 16'h0000;
    end
    else if (ce_i)
    begin
      ack_q <= bus_req;
      if (bus_req)
        rdat_q <= rmux_w;
      if (wr_en && idle && hit_cmd)
        cmd_q <= (cmd_q & ~wmask) | (wb_dat_i & wmask);
      if (wr_en && idle && hit_addr)
        addr_q <= (addr_q & ~wmask[15:0]) | (wb_dat_i[15:0] & wmask[15:0]);
      if (wr_en && hit_pc)
        pc_q <= (pc_q & ~wmask[15:0]) | (wb_dat_i[15:0] & wmask[15:0]);
      if (wr_en && hit_dec && wb_sel_i[0])
        dec_kind_q <= wb_dat_i[3:0];
      if (wr_en && hit_dec)
        dec_fld_q <= (dec_fld_q & ~wmask[31:16]) | (wb_dat_i[31:16] & wmask[31:16]);
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      for (int i = 0; i < 8; i++)
        gpr_q[i] <= 8'h00;
    end
    else if (ce_i)
    begin
      if (wr_en && idle && hit_gpr && wb_sel_i[0])
        gpr_q[gpr_sel] <= wb_dat_i[7:0];
      if (rd_ack && op_w == btod_pkg::OP_LOAD)
        gpr_q[btod_pkg::IDX_A] <= mem_rdata_i;
      if (wr_ack && op_w == btod_pkg::OP_XCHG)
        gpr_q[btod_pkg::IDX_A] <= tmp_q;
      if (fin_w && md_w == btod_pkg::MD_REG && op_w <= btod_pkg::OP_IMM)
      begin
        if (op_w == btod_pkg::OP_LOAD || op_w == btod_pkg::OP_XCHG)
          gpr_q[btod_pkg::IDX_A] <= gpr_q[ri_w];
        if (op_w != btod_pkg::OP_LOAD)
          gpr_q[ri_w] <= (op_w == btod_pkg::OP_IMM) ? imm_w : acc_w;
      end
      if (fin_w && md_w == btod_pkg::MD_PSW && op_w == btod_pkg::OP_LOAD)
        gpr_q[btod_pkg::IDX_A] <= psw_q;
    end
  end

  // Flags change only through writes of the whole status word
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      psw_q <= btod_pkg::PSW_RESET;
      psw_sv_q <= btod_pkg::PSW_RESET;
    end
    else if (ce_i)
    begin
      if (wr_en && idle && hit_psw && wb_sel_i[0])
        psw_q <= wb_dat_i[7:0];
      if (wr_en && idle && hit_psw && wb_sel_i[1])
        psw_sv_q <= wb_dat_i[15:8];
      if (fin_w && md_w == btod_pkg::MD_PSW && op_w == btod_pkg::OP_STORE)
        psw_q <= acc_w;
      if (fin_w && md_w == btod_pkg::MD_PSW && op_w == btod_pkg::OP_IMM)
        psw_q <= imm_w;
      if (fin_w && op_w == btod_pkg::OP_PSAVE)
        psw_sv_q <= psw_q;
      if (fin_w && op_w == btod_pkg::OP_PREST)
        psw_q <= psw_sv_q;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_q <= btod_pkg::BTOD_S_IDLE;
      cnt_q <= 5'h00;
      tot_q <= 8'h00;
      wait_q <= 8'h00;
      base_q <= 5'h00;
    end
    else if (ce_i)
    begin
      state_q <= state_d;
      if (idle)
        cnt_q <= 5'h00;
      else if (!stall_w)
        cnt_q <= cnt_q + 5'h01;
      tot_q <= idle ? 8'h00 : tot_q + 8'h01;
      if (idle)
        wait_q <= 8'h00;
      else if (stall_w)
        wait_q <= wait_q + 8'h01;
      if (state_q == btod_pkg::BTOD_S_DISP)
        base_q <= base_w[4:0];
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      req_q <= 1'b0;
      we_q <= 1'b0;
      maddr_q <= 16'h0000;
      mwdata_q <= 8'h00;
      tmp_q <= 8'h00;
      ea_q <= 16'h0000;
      intl_q <= 1'b0;
    end
    else if (ce_i)
    begin
      // Exchange keeps the request up from read ack into the write
      req_q <= (state_d == btod_pkg::BTOD_S_RD) || (state_d == btod_pkg::BTOD_S_WR);
      we_q <= (state_d == btod_pkg::BTOD_S_WR);
      if (state_q == btod_pkg::BTOD_S_DISP)
      begin
        maddr_q <= ea_w;
        mwdata_q <= (op_w == btod_pkg::OP_IMM) ? imm_w : acc_w;
        ea_q <= ea_w;
        intl_q <= intl_w;
      end
      if (rd_ack)
        tmp_q <= mem_rdata_i;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      done_q <= 1'b0;
      err_q <= 1'b0;
      last_cyc_q <= 8'h00;
      busy_o <= 1'b0;
      done_o <= 1'b0;
    end
    else if (ce_i)
    begin
      busy_o <= (state_d != btod_pkg::BTOD_S_IDLE);
      done_o <= fin_w;
      if (fin_w)
        last_cyc_q <= tot_q + 8'h01;
      // A finish in the same cycle as a new go cannot happen: go needs idle
      if (fin_w)
        done_q <= 1'b1;
      else if (go)
        done_q <= 1'b0;
      if (state_q == btod_pkg::BTOD_S_DISP && !legal_w)
        err_q <= 1'b1;
      else if (go)
        err_q <= 1'b0;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;
  assign mem_req_o = req_q;
  assign mem_we_o = we_q;
  assign mem_addr_o = maddr_q;
  assign mem_wdata_o = mwdata_q;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  saddr_window_a: assert property (
    (dec_kind_q == btod_pkg::DK_SADDR) |->
      in_win(dec_res_w, btod_pkg::SADDR_LO, btod_pkg::SADDR_HI))
    else $error("short-direct address outside window");
  saddr_even_a: assert property (
    (dec_kind_q == btod_pkg::DK_SADDRP && dec_ok_w) |-> !dec_res_w[0] &&
      in_win(dec_res_w, btod_pkg::SADDR_LO, btod_pkg::SADDR_HI))
    else $error("short-direct word address odd or outside window");
  sfr_hole_a: assert property (
    ((dec_kind_q == btod_pkg::DK_SFR || dec_kind_q == btod_pkg::DK_SFRP) && dec_ok_w) |->
      !in_win(dec_res_w, btod_pkg::SFR_HOLE_LO, btod_pkg::SFR_HOLE_HI))
    else $error("special register hole reached");
  abs_word_a: assert property (
    (dec_kind_q == btod_pkg::DK_ABSW && dec_ok_w) |-> !dec_res_w[0])
    else $error("word absolute address odd");
  call_table_a: assert property (
    (dec_kind_q == btod_pkg::DK_CTA) |-> in_win(dec_res_w, btod_pkg::CTA_LO, btod_pkg::CTA_HI))
    else $error("call table address out of range");
  vector_even_a: assert property (
    (dec_kind_q == btod_pkg::DK_VEC) |->
      in_win(dec_res_w, btod_pkg::VEC_LO, btod_pkg::VEC_HI) && !dec_res_w[0])
    else $error("vector address bad");
  disp_sum_a: assert property (
    (dec_kind_q == btod_pkg::DK_DISP) |->
      dec_res_w == pc_q + {{8{dec_fld_q[7]}}, dec_fld_q[7:0]})
    else $error("displacement not sign extended");
  cycle_total_a: assert property (
    $rose(done_q) |-> last_cyc_q == {3'h0, base_q} + wait_q)
    else $error("instruction length not base plus waits");
  flag_hold_a: assert property (
    (!idle && !psw_op_w && op_w != btod_pkg::OP_PREST) |=>
      (psw_q & btod_pkg::PSW_FLAG_MASK) == ($past(psw_q) & btod_pkg::PSW_FLAG_MASK))
    else $error("flags changed by a plain move");
  xchg_b2b_a: assert property (
    (rd_ack && op_w == btod_pkg::OP_XCHG && ce_i) |=> mem_req_o && mem_we_o &&
      $stable(mem_addr_o))
    else $error("exchange write not back to back");
  req_hold_a: assert property (
    (stall_w && ce_i) |=> mem_req_o && $stable(mem_addr_o) && $stable(mem_we_o))
    else $error("memory request dropped while waiting");

  xchg_wait_c: cover property (rd_ack && op_w == btod_pkg::OP_XCHG && wait_q != 8'h00);
  psw_write_c: cover property (fin_w && md_w == btod_pkg::MD_PSW && op_w == btod_pkg::OP_IMM);
  illegal_c: cover property (state_q == btod_pkg::BTOD_S_DISP && !legal_w);
endmodule

// *** hw/btod_pkg.sv ***
// Constants and types for the byte-transfer operand decoder.
// Assumes a single 40 MHz core clock and a classic Wishbone register port.
package btod_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_CMD = 8'h00;
  localparam logic [7:0] OFS_ADDR = 8'h04;
  localparam logic [7:0] OFS_STAT = 8'h08;
  localparam logic [7:0] OFS_PSW = 8'h0C;
  localparam logic [7:0] OFS_DEC = 8'h10;
  localparam logic [7:0] OFS_PC = 8'h14;
  localparam logic [7:0] OFS_GPR = 8'h20;
  // Command register fields
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_MODE_LSB = 3;
  localparam int CMD_REG_LSB = 8;
  localparam int CMD_IMM_LSB = 16;
  localparam int CMD_GO_BIT = 31;
  // Status register fields
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_DONE_BIT = 1;
  localparam int STAT_ERR_BIT = 2;
  localparam int STAT_INTL_BIT = 3;
  localparam int STAT_CYC_LSB = 8;
  localparam int STAT_EA_LSB = 16;
  // Decoder register fields
  localparam int DEC_FLD_LSB = 16;
  localparam int DEC_OK_BIT = 16;
  // Operations
  localparam logic [2:0] OP_LOAD = 3'h0;
  localparam logic [2:0] OP_STORE = 3'h1;
  localparam logic [2:0] OP_XCHG = 3'h2;
  localparam logic [2:0] OP_IMM = 3'h3;
  localparam logic [2:0] OP_PSAVE = 3'h4;
  localparam logic [2:0] OP_PREST = 3'h5;
  // Addressing modes
  localparam logic [3:0] MD_REG = 4'h0;
  localparam logic [3:0] MD_SADDR = 4'h1;
  localparam logic [3:0] MD_SFR = 4'h2;
  localparam logic [3:0] MD_ABS = 4'h3;
  localparam logic [3:0] MD_DE = 4'h4;
  localparam logic [3:0] MD_HL = 4'h5;
  localparam logic [3:0] MD_HLBYTE = 4'h6;
  localparam logic [3:0] MD_HLB = 4'h7;
  localparam logic [3:0] MD_HLC = 4'h8;
  localparam logic [3:0] MD_PSW = 4'h9;
  // Operand kinds for the decoder register
  localparam logic [3:0] DK_SADDR = 4'h0;
  localparam logic [3:0] DK_SADDRP = 4'h1;
  localparam logic [3:0] DK_SFR = 4'h2;
  localparam logic [3:0] DK_SFRP = 4'h3;
  localparam logic [3:0] DK_ABS = 4'h4;
  localparam logic [3:0] DK_ABSW = 4'h5;
  localparam logic [3:0] DK_CTA = 4'h6;
  localparam logic [3:0] DK_VEC = 4'h7;
  localparam logic [3:0] DK_BIT = 4'h8;
  localparam logic [3:0] DK_DISP = 4'h9;
  localparam logic [3:0] DK_RP = 4'hA;
  localparam logic [3:0] DK_R = 4'hB;
  // Byte register indices
  localparam logic [2:0] IDX_A = 3'h1;
  localparam logic [2:0] IDX_C = 3'h2;
  localparam logic [2:0] IDX_B = 3'h3;
  localparam logic [2:0] IDX_E = 3'h4;
  localparam logic [2:0] IDX_D = 3'h5;
  localparam logic [2:0] IDX_L = 3'h6;
  localparam logic [2:0] IDX_H = 3'h7;
  // Status word flags
  localparam logic [7:0] PSW_FLAG_MASK = 8'h51;
  localparam logic [7:0] PSW_RESET = 8'h02;
  // Address windows
  localparam logic [15:0] SADDR_LO = 16'hFE20;
  localparam logic [15:0] SADDR_HI = 16'hFF1F;
  localparam logic [15:0] SFR_BASE = 16'hFF00;
  localparam logic [15:0] SFR_HOLE_LO = 16'hFFD0;
  localparam logic [15:0] SFR_HOLE_HI = 16'hFFDF;
  localparam logic [15:0] CTA_LO = 16'h0800;
  localparam logic [15:0] CTA_HI = 16'h0FFF;
  localparam logic [15:0] VEC_LO = 16'h0040;
  localparam logic [15:0] VEC_HI = 16'h007F;
  localparam logic [15:0] HRAM_LO = 16'hFB00;
  localparam logic [15:0] HRAM_HI = 16'hFEFF;
  // Base clock counts
  localparam logic [4:0] CY_RR = 5'h02;
  localparam logic [4:0] CY_RI = 5'h04;
  localparam logic [4:0] CY_SAD_S = 5'h04;
  localparam logic [4:0] CY_SAD_L = 5'h05;
  localparam logic [4:0] CY_SADI_S = 5'h06;
  localparam logic [4:0] CY_SADI_L = 5'h07;
  localparam logic [4:0] CY_SADX_L = 5'h06;
  localparam logic [4:0] CY_ABS_S = 5'h08;
  localparam logic [4:0] CY_ABS_L = 5'h09;
  localparam logic [4:0] CY_ABSX_L = 5'h0A;
  localparam logic [4:0] CY_HLBC_S = 5'h06;
  localparam logic [4:0] CY_HLBC_L = 5'h07;
  localparam logic [4:0] CY_PSWOP = 5'h02;
  typedef enum logic [2:0] {
    BTOD_S_IDLE, BTOD_S_DISP, BTOD_S_RD, BTOD_S_WR, BTOD_S_PAD
  } btod_state_t;
endpackage

// *** dv/btod_mem_model.sv ***
// Behavioural memory behind the decoder's data port.
// Below F000H counts as external expansion with settable read/write waits.
`timescale 1ns/10ps
module btod_mem_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic req_i,
  input wire logic we_i,
  input wire logic [15:0] addr_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o,
  output logic rdy_o,
  input wire logic [3:0] rd_waits_i,
  input wire logic [3:0] wr_waits_i
);
  logic [7:0] m [0:65535];
  logic [3:0] cnt_q;
  wire ext = addr_i < 16'hF000;
  wire [3:0] waits = ext ? (we_i ? wr_waits_i : rd_waits_i) : 4'h0;
  assign rdy_o = req_i && (cnt_q == waits);
  // Inverse data outside the sampling edge so stale reads are caught
  assign rdata_o = (rdy_o && !we_i) ? m[addr_i] : ~m[addr_i];
  always @(posedge clk_i)
  begin
    if (rst_i || !req_i || rdy_o)
      cnt_q <= 4'h0;
    else
      cnt_q <= cnt_q + 4'h1;
    if (!rst_i && rdy_o && we_i)
      m[addr_i] <= wdata_i;
  end
endmodule

// *** dv/testbench.sv ***
// Self-checking bench: register port driven as a classic bus master.
// Assumes the memory model answers internal areas without waits.
`timescale 1ns/10ps
module testbench;
  logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat = 32'h0, rdat, q;
  logic ack, req, mwe, rdy, busy, done;
  logic [15:0] maddr;
  logic [7:0] wd, rd;
  logic [3:0] rw = 4'h0, ww = 4'h0;
  int errors = 0, num_checks = 0;
  btod_core DUT (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .mem_req_o(req), .mem_we_o(mwe), .mem_addr_o(maddr),
    .mem_wdata_o(wd), .mem_rdata_i(rd), .mem_rdy_i(rdy), .busy_o(busy), .done_o(done));
  btod_mem_model MEM (.clk_i(clk_i), .rst_i(rst_i), .req_i(req), .we_i(mwe),
    .addr_i(maddr), .wdata_i(wd), .rdata_o(rd), .rdy_o(rdy), .rd_waits_i(rw),
    .wr_waits_i(ww));
  initial forever #12.5 clk_i = ~clk_i;
  task report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("mismatch %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    dat <= d;
    do @(posedge clk_i); while (ack !== 1'b1);
    q = rdat;
    cyc <= 0;
    stb <= 0;
  endtask
  task rdchk(input logic [7:0] a, input logic [31:0] exp);
    wb(0, a, 32'h0);
    chk(q, exp);
  endtask
  // Start an instruction and count the busy cycles until the done pulse
  task run(input logic [2:0] op, input logic [3:0] md, input logic [2:0] r,
    input logic [7:0] imm, input int cyc_exp);
    int n;
    int k;
    n = 0;
    wb(1, btod_pkg::OFS_CMD, {1'b1, 7'h0, imm, 5'h0, r, 1'b0, md, op});
    // Busy already rose at the edge that raised ack, one edge before the bus task saw it
    if (busy === 1'b1)
      n++;
    for (k = 0; k < 60 && done !== 1'b1; k++)
    begin
      @(posedge clk_i);
      if (busy === 1'b1)
        n++;
    end
    chk(n, cyc_exp);
  endtask
  task t_reset;
    rdchk(btod_pkg::OFS_PSW, 32'h0202);
    rdchk(8'h18, 32'h0);
    $display("reset test done");
  endtask
  task t_imm;
    run(btod_pkg::OP_IMM, btod_pkg::MD_REG, btod_pkg::IDX_A, 8'h5A, 4);
    rdchk(8'h24, 32'h5A);
    $display("immediate test done");
  endtask
  task t_xch;
    MEM.m[16'hFB10] = 8'h33;
    wb(1, btod_pkg::OFS_ADDR, 32'hFB10);
    run(btod_pkg::OP_XCHG, btod_pkg::MD_ABS, 3'h0, 8'h0, 8);
    rdchk(8'h24, 32'h33);
    chk(MEM.m[16'hFB10], 32'h5A);
    MEM.m[16'h1234] = 8'hC7;
    rw <= 4'h2;
    ww <= 4'h1;
    wb(1, btod_pkg::OFS_ADDR, 32'h1234);
    run(btod_pkg::OP_XCHG, btod_pkg::MD_ABS, 3'h0, 8'h0, 13);
    rdchk(8'h24, 32'hC7);
    chk(MEM.m[16'h1234], 32'h33);
    $display("exchange test done");
  endtask
  task t_ld;
    MEM.m[16'h2000] = 8'h9E;
    rw <= 4'h3;
    wb(1, btod_pkg::OFS_ADDR, 32'h2000);
    run(btod_pkg::OP_LOAD, btod_pkg::MD_ABS, 3'h0, 8'h0, 12);
    rdchk(8'h24, 32'h9E);
    $display("absolute load test done");
  endtask
  task t_hlb;
    MEM.m[16'hFB05] = 8'h44;
    wb(1, 8'h3C, 32'hFB);
    wb(1, 8'h38, 32'h00);
    wb(1, 8'h2C, 32'h05);
    run(btod_pkg::OP_LOAD, btod_pkg::MD_HLB, 3'h0, 8'h0, 6);
    rdchk(8'h24, 32'h44);
    ww <= 4'h2;
    wb(1, 8'h3C, 32'h20);
    run(btod_pkg::OP_STORE, btod_pkg::MD_HLB, 3'h0, 8'h0, 9);
    chk(MEM.m[16'h2005], 32'h44);
    $display("pointer plus offset test done");
  endtask
  task t_dec;
    wb(1, btod_pkg::OFS_PC, 32'h0100);
    wb(1, btod_pkg::OFS_DEC, {16'h0000, 12'h0, btod_pkg::DK_SADDR});
    rdchk(btod_pkg::OFS_DEC, 32'h1FF00);
    wb(1, btod_pkg::OFS_DEC, {16'h00FE, 12'h0, btod_pkg::DK_DISP});
    rdchk(btod_pkg::OFS_DEC, 32'h100FE);
    wb(1, btod_pkg::OFS_DEC, {16'h0005, 12'h0, btod_pkg::DK_BIT});
    rdchk(btod_pkg::OFS_DEC, 32'h10020);
    rdchk(btod_pkg::OFS_PSW, 32'h0202);
    wb(1, btod_pkg::OFS_PSW, 32'h5102);
    run(btod_pkg::OP_PREST, btod_pkg::MD_REG, 3'h0, 8'h0, 2);
    rdchk(btod_pkg::OFS_PSW, 32'h5151);
    $display("decode test done");
  endtask
  initial
  begin
    repeat (3) @(posedge clk_i);
    rst_i <= 0;
    t_reset();
    t_imm();
    t_xch();
    t_ld();
    t_hlb();
    t_dec();
    report_and_stop();
  end
  // Whole run needs well under a thousand cycles
  initial
  begin
    repeat (5000) @(posedge clk_i);
    errors++;
    report_and_stop();
  end
endmodule
